// File: src/adcs_pkg.sv
// package: register map, field positions and constants of the converter sequencer
package adcs_pkg;
  // ------------------------------------------------------------
  // register byte offsets on the apb bus
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL_0 = 8'h00; // start, busy, enable, format, channel
  localparam logic [7:0] ADDR_CONTROL_1 = 8'h04; // source, reference, clock divider
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h08; // result_high_byte, read only
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h0C; // result_low_byte, read only
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10; // sticky events, write one to clear
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14; // interrupt enables

  // ------------------------------------------------------------
  // control 0 field positions
  // ------------------------------------------------------------
  localparam int BIT_START = 7;
  localparam int BIT_BUSY = 6;
  localparam int BIT_ENABLE = 5;
  localparam int BIT_JUSTIFY = 4;
  // control 1 field positions
  localparam int POS_SOURCE = 5;
  localparam int POS_REFERENCE = 3;
  localparam int POS_CLKDIV = 0;

  // ------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------
  localparam logic [7:0] RESET_CONTROL_0 = 8'h00;
  localparam logic [7:0] RESET_CONTROL_1 = 8'h00;
  localparam logic [11:0] RESET_RESULT = 12'h000;
  localparam logic [3:0] CHAN_LAST_EXT = 4'h5; // codes above float
  localparam logic [2:0] SRC_OVERCURRENT = 3'h1;
  localparam logic [2:0] SRC_DCDC = 3'h2;
  localparam logic [1:0] REF_SUPPLY = 2'h1;

  // ------------------------------------------------------------
  // conversion timing in converter clocks
  // ------------------------------------------------------------
  localparam logic [4:0] SAMPLE_CLOCKS = 5'h04;
  localparam logic [4:0] CONVERT_CLOCKS = 5'h0C;
  localparam logic [4:0] TOTAL_CLOCKS = 5'h10;
  localparam int IRQ_BIT_DONE = 0; // conversion complete event

  typedef enum logic [1:0] {
    ADCS_IDLE,
    ADCS_ARMED,
    ADCS_SAMPLE,
    ADCS_CONVERT
  } adcs_state_t;
endpackage

// File: src/adcs_clock_divider.sv
// module: converter clock enable generator, divides the system clock
`timescale 1ns/10ps
`default_nettype none
module adcs_clock_divider
  import adcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [2:0] divSel,
  output logic tick
);
  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic [6:0] count; // cycles since last tick
    logic tick;        // one system cycle per converter clock
  } adcs_div_t;

  adcs_div_t cur;
  adcs_div_t next_cur;

  // terminal count 2^sel - 1 for divide by 1..128
  function automatic logic [6:0] lastCount(input logic [2:0] sel);
    lastCount = 7'((8'h01 << sel) - 8'h01);
  endfunction

  // next-state: count restarts whenever run is low, phase is aligned
  always_comb begin
    next_cur = cur;
    next_cur.tick = 1'b0;
    if (!run) begin
      next_cur.count = 7'h00;
    end else if (cur.count >= lastCount(divSel)) begin
      next_cur.count = 7'h00;
      next_cur.tick = 1'b1;
    end else begin
      next_cur.count = 7'(cur.count + 7'h01);
    end
  end

  // register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign tick = cur.tick;
endmodule
`default_nettype wire

// File: src/adcs_sequencer.sv
// module: converter control sequencer with apb registers and interrupt
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - start rise resets, fall begins conversion
// - start held high never converts
// - busy read only, set during conversion
// - completion sets flag, enabled raises irq
// - enable powers core; disabled results read zero
// - format bit picks left or right justify
// - unused result bits read zero
// - channel codes 0-5 connect, others float
// - source 001 overcurrent, 010 dcdc, else external
// - reference code 01 supply, else reference pin
// - clock divide by two power of select
// - sixteen clocks: four sample, twelve convert
module adcs_sequencer
  import adcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog core side
  input wire logic [11:0] coreResult,
  output logic corePowerOn,
  output logic coreReset,
  output logic coreSample,
  output logic coreConvert,
  output logic coreClockTick,
  output logic [5:0] extChannelConnect,
  output logic selOvercurrent,
  output logic selDcdc,
  output logic selSupplyRef,
  // interrupt
  output logic irq
);
  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic startBit;          // start bit as written
    logic enable;            // converter_enable
    logic justify;           // result_justify_sel
    logic [3:0] channel;     // ext_channel_sel
    logic [7:0] control1;    // source, reference, divider
    logic busy;              // conv_busy_flag
    adcs_state_t phase;      // sequencer phase
    logic [4:0] clocks;      // converter clocks in this phase
    logic [11:0] result;     // captured conversion result
    logic irqStatus;         // sticky completion event
    logic irqMask;           // completion interrupt enable
    logic coreReset;         // one-cycle reset pulse to core
    logic [31:0] rdata;      // registered read data
  } adcs_regs_t;

  adcs_regs_t cur;
  adcs_regs_t next_cur;
  logic tick;                // one converter clock elapsed
  logic [2:0] divSel;        // clock divider select field
  logic [2:0] srcSel;        // input source field
  logic [1:0] refSel;        // reference field
  logic wrEn;                // apb write strobe
  logic rdEn;                // apb read strobe
  logic wrStart;             // start bit value being written
  logic doneEvent;           // conversion finishes this cycle
  logic [15:0] resPair;      // justified high:low result pair

  // --------------------------------------------------------------
  // field decode
  // --------------------------------------------------------------
  assign divSel = cur.control1[POS_CLKDIV +: 3];
  assign srcSel = cur.control1[POS_SOURCE +: 3];
  assign refSel = cur.control1[POS_REFERENCE +: 2];
  // zero-wait slave: every access completes in its first access cycle
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign wrStart = pwdata[BIT_START];

  // justify result into a 16-bit high:low pair, unused bits zero
  function automatic logic [15:0] packResult(input logic [11:0] r,
                                             input logic rightJust,
                                             input logic on);
    if (!on) begin
      packResult = 16'h0000;
    end else if (rightJust) begin
      packResult = {4'h0, r};
    end else begin
      packResult = {r, 4'h0};
    end
  endfunction

  // --------------------------------------------------------------
  // converter clock
  // --------------------------------------------------------------
  // divider only runs while a conversion is active, so the first
  // converter clock is a full period after the start falls
  adcs_clock_divider uDivider (
    .clk(clk),
    .rst_n(rst_n),
    .run(cur.phase == ADCS_SAMPLE || cur.phase == ADCS_CONVERT),
    .divSel(divSel),
    .tick(tick)
  );

  // one shared copy, a select on a call result is not portable
  assign resPair = packResult(cur.result, cur.justify, cur.enable);

  assign doneEvent = tick && cur.phase == ADCS_CONVERT &&
                     cur.clocks == CONVERT_CLOCKS - 5'h01;

  // --------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.coreReset = 1'b0;
    next_cur.rdata = 32'h0000_0000;

    // sequencer phases
    unique case (cur.phase)
      ADCS_IDLE, ADCS_ARMED: begin
        next_cur.clocks = 5'h00;
      end
      ADCS_SAMPLE: begin
        if (tick) begin
          if (cur.clocks == SAMPLE_CLOCKS - 5'h01) begin
            next_cur.phase = ADCS_CONVERT;
            next_cur.clocks = 5'h00;
          end else begin
            next_cur.clocks = 5'(cur.clocks + 5'h01);
          end
        end
      end
      ADCS_CONVERT: begin
        if (tick) begin
          if (doneEvent) begin
            next_cur.phase = ADCS_IDLE;
            next_cur.busy = 1'b0;
            next_cur.result = coreResult;
            next_cur.clocks = 5'h00;
          end else begin
            next_cur.clocks = 5'(cur.clocks + 5'h01);
          end
        end
      end
    endcase

    // completion sets the sticky flag; set beats a same-cycle clear
    if (wrEn && paddr == ADDR_IRQ_STATUS && pwdata[IRQ_BIT_DONE]) begin
      next_cur.irqStatus = 1'b0;
    end
    if (doneEvent) begin
      next_cur.irqStatus = 1'b1;
    end

    // register writes
    if (wrEn) begin
      unique case (paddr)
        ADDR_CONTROL_0: begin
          next_cur.startBit = wrStart;
          next_cur.enable = pwdata[BIT_ENABLE];
          next_cur.justify = pwdata[BIT_JUSTIFY];
          next_cur.channel = pwdata[3:0];
          // rising start: reset core, abort, clear busy
          if (wrStart && !cur.startBit) begin
            next_cur.coreReset = 1'b1;
            next_cur.busy = 1'b0;
            next_cur.phase = ADCS_ARMED;
            next_cur.clocks = 5'h00;
          end
          // falling start after a rise: begin conversion
          if (!wrStart && cur.startBit && cur.phase == ADCS_ARMED &&
              pwdata[BIT_ENABLE]) begin
            next_cur.busy = 1'b1;
            next_cur.phase = ADCS_SAMPLE;
          end
        end
        ADDR_CONTROL_1: begin
          next_cur.control1 = pwdata[7:0];
        end
        ADDR_IRQ_MASK: begin
          next_cur.irqMask = pwdata[IRQ_BIT_DONE];
        end
        default: begin
          next_cur.control1 = cur.control1;
        end
      endcase
    end

    // disabling stops any conversion and clears the results
    if (!next_cur.enable) begin
      next_cur.result = RESET_RESULT;
      next_cur.busy = 1'b0;
      if (next_cur.phase != ADCS_ARMED) begin
        next_cur.phase = ADCS_IDLE;
      end
    end

    // register reads, captured in the access cycle
    if (rdEn) begin
      unique case (paddr)
        ADDR_CONTROL_0: begin
          next_cur.rdata = {24'h00_0000, cur.startBit, cur.busy,
                            cur.enable, cur.justify, cur.channel};
        end
        ADDR_CONTROL_1: begin
          next_cur.rdata = {24'h00_0000, cur.control1};
        end
        ADDR_RESULT_HIGH: begin
          next_cur.rdata = {24'h00_0000, resPair[15:8]};
        end
        ADDR_RESULT_LOW: begin
          next_cur.rdata = {24'h00_0000, resPair[7:0]};
        end
        ADDR_IRQ_STATUS: begin
          next_cur.rdata = {31'h0000_0000, cur.irqStatus};
        end
        ADDR_IRQ_MASK: begin
          next_cur.rdata = {31'h0000_0000, cur.irqMask};
        end
        default: begin
          next_cur.rdata = 32'h0000_0000; // unmapped reads zero
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  // read data is combinational from state so it is valid in the
  // same access cycle that pready is high
  always_comb begin
    unique case (paddr)
      ADDR_CONTROL_0: prdata = {24'h00_0000, cur.startBit, cur.busy,
                                cur.enable, cur.justify, cur.channel};
      ADDR_CONTROL_1: prdata = {24'h00_0000, cur.control1};
      ADDR_RESULT_HIGH: prdata = {24'h00_0000, resPair[15:8]};
      ADDR_RESULT_LOW: prdata = {24'h00_0000, resPair[7:0]};
      ADDR_IRQ_STATUS: prdata = {31'h0000_0000, cur.irqStatus};
      ADDR_IRQ_MASK: prdata = {31'h0000_0000, cur.irqMask};
      default: prdata = 32'h0000_0000;
    endcase
  end

  assign pready = 1'b1;
  // unmapped addresses answer with an error
  assign pslverr = psel && penable &&
                   !(paddr == ADDR_CONTROL_0 || paddr == ADDR_CONTROL_1 ||
                     paddr == ADDR_RESULT_HIGH || paddr == ADDR_RESULT_LOW ||
                     paddr == ADDR_IRQ_STATUS || paddr == ADDR_IRQ_MASK);

  assign irq = cur.irqStatus && cur.irqMask;
  assign corePowerOn = cur.enable;
  assign coreReset = cur.coreReset;
  assign coreSample = cur.phase == ADCS_SAMPLE;
  assign coreConvert = cur.phase == ADCS_CONVERT;
  assign coreClockTick = tick;

  // analog input routing
  always_comb begin
    extChannelConnect = 6'h00;
    if (cur.channel <= CHAN_LAST_EXT) begin
      extChannelConnect[cur.channel[2:0]] = 1'b1;
    end
  end
  assign selOvercurrent = srcSel == SRC_OVERCURRENT;
  assign selDcdc = srcSel == SRC_DCDC;
  assign selSupplyRef = refSel == REF_SUPPLY;
endmodule
`default_nettype wire

// File: testbench/adcs_sequencer_chk.sv
// checker: port level assertions for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module adcs_sequencer_chk
  import adcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic coreReset,
  input wire logic corePowerOn,
  input wire logic coreSample,
  input wire logic coreConvert,
  input wire logic coreClockTick,
  input wire logic [5:0] extChannelConnect,
  input wire logic selOvercurrent,
  input wire logic selDcdc,
  input wire logic selSupplyRef
);
  // ------------------------------
  // helper logic
  // ------------------------------
  logic [31:0] lastWd; // write data one cycle back
  logic [4:0] sCnt; // ticks seen while sampling
  logic [4:0] cCnt; // ticks seen while converting
  logic wr0; // accepted write to control 0
  logic wr1; // accepted write to control 1
  logic rdRes; // read of either result byte
  assign wr0 = psel && penable && pwrite && paddr == ADDR_CONTROL_0;
  assign wr1 = psel && penable && pwrite && paddr == ADDR_CONTROL_1;
  assign rdRes = psel && penable && !pwrite &&
    (paddr == ADDR_RESULT_HIGH || paddr == ADDR_RESULT_LOW);
  // counters clear between phases so an abort never leaks into the next run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lastWd <= 32'h0000_0000;
      sCnt <= 5'h00;
      cCnt <= 5'h00;
    end else begin
      lastWd <= pwdata;
      sCnt <= coreSample ? sCnt + 5'(coreClockTick) : 5'h00;
      cCnt <= coreConvert ? cCnt + 5'(coreClockTick) : 5'h00;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------
  // assertions
  // ------------------------------
  reset_pulse_a:
    assert property (coreReset |-> !coreSample && !coreConvert ##1 !coreReset)
      else $error("core reset not a clean single pulse");
  power_follow_a:
    assert property (wr0 |=> corePowerOn == lastWd[BIT_ENABLE])
      else $error("core power does not follow enable");
  off_zero_a:
    assert property (rdRes && !corePowerOn |-> prdata == 32'h0000_0000)
      else $error("result nonzero while disabled");
  chan_decode_a:
    assert property (wr0 |=> extChannelConnect == (lastWd[3:0] <= CHAN_LAST_EXT
      ? 6'h01 << lastWd[3:0] : 6'h00))
      else $error("channel connect decode wrong");
  src_decode_a:
    assert property (wr1 |=> selOvercurrent == (lastWd[7:5] == SRC_OVERCURRENT)
      && selDcdc == (lastWd[7:5] == SRC_DCDC))
      else $error("input source decode wrong");
  ref_decode_a:
    assert property (wr1 |=> selSupplyRef == (lastWd[4:3] == REF_SUPPLY))
      else $error("reference decode wrong");
  sample_len_a:
    assert property ($rose(coreConvert) |-> sCnt == SAMPLE_CLOCKS)
      else $error("sampling phase length wrong");
  convert_len_a:
    assert property ($fell(coreConvert) && corePowerOn && !coreReset
      |-> cCnt == CONVERT_CLOCKS)
      else $error("conversion phase length wrong");
  phase_excl_a:
    assert property (!(coreSample && coreConvert))
      else $error("sample and convert overlap");
endmodule
`default_nettype wire

// File: testbench/adcs_core_model.sv
// partner: behavioural analog sample-and-convert core
`timescale 1ns/10ps
`default_nettype none
module adcs_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic corePowerOn,
  input wire logic coreSample,
  input wire logic [11:0] level,
  output logic [11:0] coreResult
);
  logic [11:0] held; // value taken while sampling
  logic [11:0] junk; // flips each cycle, so when off the stale held value shows every other cycle
  // the level is only taken during sampling, late changes are ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= 12'h000;
      junk <= 12'h000;
    end else begin
      if (coreSample) begin
        held <= level;
      end
      junk <= ~junk;
    end
  end
  // powered down core alternates the held value and its inverse each cycle
  assign coreResult = corePowerOn ? held : junk ^ held;
endmodule
`default_nettype wire

// File: testbench/tb_adc_control_sequencer.sv
// testbench: apb driven tests of the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_adc_control_sequencer;
  import adcs_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [11:0] coreResult, level;
  logic corePowerOn, coreReset, coreSample, coreConvert, coreClockTick;
  logic [5:0] extChannelConnect;
  logic selOvercurrent, selDcdc, selSupplyRef, irq;
  logic err; // pslverr at the taking edge
  int failures, n_checks, cyc;
  localparam logic [7:0] ADR[6] = '{ADDR_CONTROL_0, ADDR_CONTROL_1,
    ADDR_RESULT_HIGH, ADDR_RESULT_LOW, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
  adcs_sequencer dut_u (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .coreResult(coreResult),
    .corePowerOn(corePowerOn), .coreReset(coreReset),
    .coreSample(coreSample), .coreConvert(coreConvert),
    .coreClockTick(coreClockTick), .extChannelConnect(extChannelConnect),
    .selOvercurrent(selOvercurrent), .selDcdc(selDcdc),
    .selSupplyRef(selSupplyRef), .irq(irq));
  adcs_core_model core_u (.clk(clk), .rst_n(rst_n),
    .corePowerOn(corePowerOn), .coreSample(coreSample), .level(level),
    .coreResult(coreResult));
  // 250 mhz system clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; returns 1 ns after the taking edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // one full conversion, divider code and justification from the index
  task automatic conv(input int i);
    logic [2:0] dv;
    logic [7:0] b;
    logic [11:0] r;
    dv = 3'(i);
    r = 12'(i * 32'h0000_0539) ^ 12'h9C3;
    b = {2'h0, 1'h1, i[0], 4'h0};
    level <= r;
    apb(1, ADDR_IRQ_MASK, 32'(!i[1]));
    apb(1, ADDR_CONTROL_1, 32'(dv));
    apb(1, ADDR_CONTROL_0, 32'(b));
    repeat (8) @(posedge clk);
    apb(1, ADDR_CONTROL_0, 32'(b | 8'h80));
    repeat (20) @(posedge clk);
    apb(0, ADDR_CONTROL_0, 0);
    chk("busy with start high", 0, q[BIT_BUSY]);
    apb(1, ADDR_CONTROL_0, 32'(b));
    // divider tick is registered, so completion lands one cycle late
    repeat (16 << dv) @(posedge clk);
    #1 chk("converting", 1, coreConvert);
    @(posedge clk);
    #1 chk("irq at done", !i[1], irq);
    apb(0, ADDR_CONTROL_0, 0);
    chk("busy after done", 0, q[BIT_BUSY]);
    apb(0, ADDR_RESULT_HIGH, 0);
    chk("high", i[0] ? 32'(r[11:8]) : 32'(r[11:4]), q);
    apb(0, ADDR_RESULT_LOW, 0);
    chk("low", i[0] ? 32'(r[7:0]) : 32'({r[3:0], 4'h0}), q);
    apb(0, ADDR_IRQ_STATUS, 0);
    chk("status", 1, q);
    apb(1, ADDR_IRQ_MASK, 1);
    chk("irq unmasked", 1, irq);
    apb(1, ADDR_IRQ_STATUS, 1);
    chk("irq cleared", 0, irq);
    $display("test conversion %0d done", i);
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard, well above the longest expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      wrap_up();
    end
  end
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    level = 12'h000;
    cyc = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ADR[k]) begin
      apb(0, ADR[k], 0);
      chk("reset value", 0, q);
    end
    chk("channel at reset", 6'h01, extChannelConnect);
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      apb(1, ADDR_CONTROL_0, 32'(c));
      chk("channel", c < 6 ? 32'(1 << c) : 0, extChannelConnect);
    end
    // channel left floating before any internal source
    for (int s = 0; s < 8; s++) begin
      apb(1, ADDR_CONTROL_1, 32'({3'(s), 2'(s), 3'h0}));
      chk("overcurrent", s == 1, selOvercurrent);
      chk("dcdc", s == 2, selDcdc);
      chk("supply ref", s % 4 == 1, selSupplyRef);
      apb(0, ADDR_CONTROL_1, 0);
      chk("control 1", 32'({3'(s), 2'(s), 3'h0}), q);
    end
    $display("test selects done");
    for (int i = 0; i < 8; i++) begin
      conv(i);
    end
    // abort by disable, divider 7 keeps a 512 ns converter clock
    apb(1, ADDR_CONTROL_1, 32'h0000_0007);
    apb(1, ADDR_CONTROL_0, 32'h0000_00E0);
    apb(1, ADDR_CONTROL_0, 32'h0000_0020);
    apb(0, ADDR_CONTROL_0, 0);
    chk("busy running", 1, q[BIT_BUSY]);
    apb(1, ADDR_CONTROL_0, 32'h0000_0040);
    apb(0, ADDR_CONTROL_0, 0);
    chk("busy not writable", 0, q);
    repeat (2100) @(posedge clk);
    apb(0, ADDR_IRQ_STATUS, 0);
    chk("no event on abort", 0, q);
    apb(0, ADDR_RESULT_HIGH, 0);
    chk("high off", 0, q);
    apb(0, ADDR_RESULT_LOW, 0);
    chk("low off", 0, q);
    $display("test abort done");
    apb(1, 8'h18, 32'h0000_00FF);
    chk("unmapped write error", 1, err);
    apb(0, 8'h18, 0);
    chk("unmapped read", 0, q);
    chk("unmapped read error", 1, err);
    $display("test unmapped done");
    wrap_up();
  end
endmodule
bind adcs_sequencer adcs_sequencer_chk chk_u (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .coreReset(coreReset),
  .corePowerOn(corePowerOn), .coreSample(coreSample),
  .coreConvert(coreConvert), .coreClockTick(coreClockTick),
  .extChannelConnect(extChannelConnect), .selOvercurrent(selOvercurrent),
  .selDcdc(selDcdc), .selSupplyRef(selSupplyRef));
`default_nettype wire
